// >>> rtl/adsc_params.svh
/*
   offsets, field positions, reset values and timing counts of the
   converter sleep control block.
   assumes: included by bare name from the design files and the checker.
*/
`ifndef ADSC_PARAMS_SVH
`define ADSC_PARAMS_SVH

// register byte offsets on the apb slave
`define ADSC_OFS_CTRL      8'h00
`define ADSC_OFS_STAT      8'h04
`define ADSC_OFS_RESULT    8'h08
`define ADSC_OFS_IRQ_STAT  8'h0C
`define ADSC_OFS_IRQ_MASK  8'h10

// control register fields
`define ADSC_CTRL_ON       0
`define ADSC_CTRL_GO       2
`define ADSC_CTRL_CS_LO    6
`define ADSC_CTRL_CS_HI    7
`define ADSC_CTRL_IE       8
`define ADSC_CTRL_DIG_LO   16
`define ADSC_CTRL_DIG_HI   20

// status register fields
`define ADSC_STAT_BUSY     0
`define ADSC_STAT_PWR      1
`define ADSC_STAT_SLEEP    2

// event bits, same layout in status and mask
`define ADSC_EV_DONE       0
`define ADSC_EV_ABORT      1
`define ADSC_EV_WAKE       2

// clock select encoding of the internal rc source
`define ADSC_CS_RC         2'h3

// reset values
`define ADSC_IRQ_MASK_RST  3'h0

// timing: pclk period and one instruction cycle, in ns
`define ADSC_PCLK_NS       4
`define ADSC_INSTR_NS      16
`define ADSC_INSTR_CYC     ((`ADSC_INSTR_NS + `ADSC_PCLK_NS - 1) / `ADSC_PCLK_NS)
// rc source tick divider and conversion length in ticks
`define ADSC_RC_DIV        16
`define ADSC_CONV_TICKS    11

`endif

// >>> rtl/adsc_pkg.sv
/*
   types of the converter sleep control block: states, bus carriers,
   and the packed state of each module.
   assumes: constants come from adsc_params.svh.
*/
package adsc_pkg;

   // conversion sequencer, gray along idle -> wait -> run
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_RUN  = 2'b11
   } adsc_state_e;

   // apb request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } adsc_apb_req_s;

   // apb answer to the master
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } adsc_apb_rsp_s;

   // software control fields
   typedef struct packed {
      logic [4:0] dig_sel;
      logic       irq_en;
      logic [1:0] clk_sel;
      logic       go;
      logic       on;
   } adsc_ctrl_s;

   // whole state of the top module
   typedef struct packed {
      adsc_ctrl_s  ctrl;
      logic [2:0]  irq_stat;
      logic [2:0]  irq_mask;
      logic [4:0]  pre_cnt;
      logic [3:0]  rc_cnt;
      logic [9:0]  samp_s1;
      logic [9:0]  samp_s2;
      logic        wake;
      logic [31:0] rdata;
   } adsc_top_s;

   // whole state of the sequencer (result kept apart, it has no reset)
   typedef struct packed {
      adsc_state_e st;
      logic [3:0]  cnt;
      logic        done;
   } adsc_conv_s;

endpackage : adsc_pkg

// >>> rtl/adsc_conv.sv
/*
   conversion sequencer: optional one instruction cycle start delay,
   a fixed number of converter clock ticks, then a done pulse and a
   result capture.
   assumes: tick is a one-cycle enable on pclk; abort may come any cycle.
*/
`timescale 1ns/1ns
`include "adsc_params.svh"

module adsc_conv
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // control
   input  wire logic        start,
   input  wire logic        use_rc,
   input  wire logic        abort,
   input  wire logic        tick,
   // analog value, already synchronised
   input  wire logic [9:0]  sample,
   // status
   output logic             busy,
   output logic             done,
   output logic [9:0]       result
);
   import adsc_pkg::*;

   adsc_conv_s r_reg;
   adsc_conv_s r_next;
   logic       finish;

   // last tick of a running conversion
   assign finish = (r_reg.st == ST_RUN) && tick && (r_reg.cnt == 4'h0) && !abort;

   // sequencer next state
   always_comb
   begin
      r_next      = r_reg;
      r_next.done = 1'b0;
      case (r_reg.st)
         ST_IDLE:
         begin
            if (start && use_rc)
            begin
               r_next.st  = ST_WAIT;
               r_next.cnt = 4'(`ADSC_INSTR_CYC - 1);
            end
            else if (start)
            begin
               r_next.st  = ST_RUN;
               r_next.cnt = 4'(`ADSC_CONV_TICKS - 1);
            end
         end
         ST_WAIT:
         begin
            // delay lets the core reach sleep before any sampling noise
            if (r_reg.cnt == 4'h0)
            begin
               r_next.st  = ST_RUN;
               r_next.cnt = 4'(`ADSC_CONV_TICKS - 1);
            end
            else
            begin
               r_next.cnt = r_reg.cnt - 4'h1;
            end
         end
         ST_RUN:
         begin
            if (finish)
            begin
               r_next.st   = ST_IDLE;
               r_next.done = 1'b1;
            end
            else if (tick)
            begin
               r_next.cnt = r_reg.cnt - 4'h1;
            end
         end
         default:
         begin
            r_next.st = ST_IDLE;
         end
      endcase
      // abort wins over everything, no done and no result
      if (abort)
      begin
         r_next.st   = ST_IDLE;
         r_next.cnt  = 4'h0;
         r_next.done = 1'b0;
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r_reg <= '{st: ST_IDLE, cnt: 4'h0, done: 1'b0};
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // result holds its value through any reset, unknown after power-up
   always_ff @(posedge pclk)
   begin
      if (finish)
      begin
         result <= sample;
      end
   end

   assign busy = (r_reg.st != ST_IDLE);
   assign done = r_reg.done;

endmodule : adsc_conv

// >>> rtl/adsc_top.sv
/*
   converter sleep control: apb registers, converter clock dividers,
   sleep abort and wake-up, sticky events with a masked interrupt.
   assumes: core_sleep comes from core logic on pclk; conv_sample comes
   from the analog side and is synchronised here.

*/
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "adsc_params.svh"

module adsc_top
(
   // clock and reset
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   // apb slave
   input  wire adsc_pkg::adsc_apb_req_s apb_req,
   output adsc_pkg::adsc_apb_rsp_s      apb_rsp,
   // core sleep and wake
   input  wire logic                    core_sleep,
   output logic                         core_wake,
   // analog side
   input  wire logic [9:0]              conv_sample,
   output logic                         analog_powered,
   output logic [4:0]                   pin_analog,
   // interrupt
   output logic                         irq
);
   import adsc_pkg::*;

   adsc_top_s   r_reg;
   adsc_top_s   r_next;
   logic        rc_sel;
   logic        sleep_abort;
   logic        abort;
   logic        tick;
   logic        fosc_tick;
   logic        setup;
   logic        access;
   logic        wr_ctrl;
   logic        start;
   logic        busy;
   logic        done;
   logic [9:0]  result;
   logic [2:0]  ev;

   // register index of an address, 3'h7 when unmapped
   function automatic logic [2:0] reg_index(input logic [7:0] addr);
      case (addr)
         `ADSC_OFS_CTRL:     reg_index = 3'h0;
         `ADSC_OFS_STAT:     reg_index = 3'h1;
         `ADSC_OFS_RESULT:   reg_index = 3'h2;
         `ADSC_OFS_IRQ_STAT: reg_index = 3'h3;
         `ADSC_OFS_IRQ_MASK: reg_index = 3'h4;
         default:            reg_index = 3'h7;
      endcase
   endfunction : reg_index

   // core-derived converter clocks: fosc/2, /8, /32 from the prescaler
   function automatic logic fosc_pick(input logic [1:0] sel, input logic [4:0] cnt);
      case (sel)
         2'h0:    fosc_pick = (cnt[0] == 1'b1);
         2'h1:    fosc_pick = (cnt[2:0] == 3'h7);
         2'h2:    fosc_pick = (cnt == 5'h1F);
         default: fosc_pick = 1'b0;
      endcase
   endfunction : fosc_pick

   // clock choice and sleep consequences
   assign rc_sel      = (r_reg.ctrl.clk_sel == `ADSC_CS_RC);
   assign sleep_abort = core_sleep && !rc_sel;
   // off aborts, except in the write that switches on and starts at once
   assign abort       = sleep_abort || (!r_reg.ctrl.on && !start);
   assign fosc_tick   = fosc_pick(r_reg.ctrl.clk_sel, r_reg.pre_cnt);
   assign tick        = rc_sel ? (r_reg.rc_cnt == 4'(`ADSC_RC_DIV - 1)) : fosc_tick;

   // apb phases; zero wait states, so pready is tied high
   assign setup   = apb_req.psel && !apb_req.penable;
   assign access  = apb_req.psel && apb_req.penable;
   assign wr_ctrl = access && apb_req.pwrite && (reg_index(apb_req.paddr) == 3'h0);
   // go written with converter on starts a new conversion when idle
   assign start   = wr_ctrl && apb_req.pwdata[`ADSC_CTRL_GO] &&
                    apb_req.pwdata[`ADSC_CTRL_ON] && !busy && !sleep_abort;

   adsc_conv u_conv
   (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (start),
      .use_rc  (apb_req.pwdata[`ADSC_CTRL_CS_HI:`ADSC_CTRL_CS_LO] == `ADSC_CS_RC),
      .abort   (abort),
      .tick    (tick),
      .sample  (r_reg.samp_s2),
      .busy    (busy),
      .done    (done),
      .result  (result)
   );

   // events of this cycle
   always_comb
   begin
      ev                = 3'h0;
      ev[`ADSC_EV_DONE] = done;
      ev[`ADSC_EV_ABORT] = busy && sleep_abort;
      ev[`ADSC_EV_WAKE] = done && core_sleep && r_reg.ctrl.irq_en;
   end

   // next state of the whole block
   always_comb
   begin
      r_next         = r_reg;
      // analog value crosses in through two flops
      r_next.samp_s1 = conv_sample;
      r_next.samp_s2 = r_reg.samp_s1;
      // core-clock prescaler stops while the core sleeps; rc runs on
      r_next.pre_cnt = core_sleep ? r_reg.pre_cnt : r_reg.pre_cnt + 5'h1;
      r_next.rc_cnt  = (r_reg.rc_cnt == 4'(`ADSC_RC_DIV - 1)) ? 4'h0 : r_reg.rc_cnt + 4'h1;
      // wake pulse to the core; without enable nothing happens
      r_next.wake    = ev[`ADSC_EV_WAKE];
      // read data prepared in the setup cycle
      if (setup)
      begin
         r_next.rdata = 32'h0000_0000;
         case (reg_index(apb_req.paddr))
            3'h0:
            begin
               r_next.rdata[`ADSC_CTRL_ON]   = r_reg.ctrl.on;
               r_next.rdata[`ADSC_CTRL_GO]   = r_reg.ctrl.go;
               r_next.rdata[`ADSC_CTRL_CS_HI:`ADSC_CTRL_CS_LO] = r_reg.ctrl.clk_sel;
               r_next.rdata[`ADSC_CTRL_IE]   = r_reg.ctrl.irq_en;
               r_next.rdata[`ADSC_CTRL_DIG_HI:`ADSC_CTRL_DIG_LO] = r_reg.ctrl.dig_sel;
            end
            3'h1:
            begin
               r_next.rdata[`ADSC_STAT_BUSY]  = busy;
               r_next.rdata[`ADSC_STAT_PWR]   = analog_powered;
               r_next.rdata[`ADSC_STAT_SLEEP] = core_sleep;
            end
            3'h2:    r_next.rdata[9:0] = result;
            3'h3:    r_next.rdata[2:0] = r_reg.irq_stat;
            3'h4:    r_next.rdata[2:0] = r_reg.irq_mask;
            default: r_next.rdata = 32'h0000_0000;
         endcase
      end
      // register writes
      if (access && apb_req.pwrite)
      begin
         case (reg_index(apb_req.paddr))
            3'h0:
            begin
               r_next.ctrl.on      = apb_req.pwdata[`ADSC_CTRL_ON];
               r_next.ctrl.go      = start;
               r_next.ctrl.clk_sel = apb_req.pwdata[`ADSC_CTRL_CS_HI:`ADSC_CTRL_CS_LO];
               r_next.ctrl.irq_en  = apb_req.pwdata[`ADSC_CTRL_IE];
               r_next.ctrl.dig_sel = apb_req.pwdata[`ADSC_CTRL_DIG_HI:`ADSC_CTRL_DIG_LO];
            end
            3'h4:    r_next.irq_mask = apb_req.pwdata[2:0];
            default: r_next.irq_mask = r_next.irq_mask;
         endcase
      end
      // hardware clears go on completion or abort; on stays as written
      // a new start in the cycle of the old done keeps go set for the new run
      if ((done && !start) || (busy && abort))
      begin
         r_next.ctrl.go = 1'b0;
      end
      // sticky events: read clears, a new event in that cycle survives
      if (access && !apb_req.pwrite && (reg_index(apb_req.paddr) == 3'h3))
      begin
         r_next.irq_stat = 3'h0;
      end
      r_next.irq_stat = r_next.irq_stat | ev;
   end

   // state register; reset switches off and aborts
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r_reg          <= '0;
         r_reg.irq_mask <= `ADSC_IRQ_MASK_RST;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // outputs
   assign analog_powered  = r_reg.ctrl.on && !sleep_abort;
   assign pin_analog      = ~r_reg.ctrl.dig_sel;
   assign core_wake       = r_reg.wake;
   assign irq             = |(r_reg.irq_stat & r_reg.irq_mask);
   assign apb_rsp.prdata  = r_reg.rdata;
   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = access && (reg_index(apb_req.paddr) == 3'h7);

endmodule : adsc_top

// >>> verification/adsc_top_asserts.sv
/*
   port checks of the converter sleep control block.
   assumes: bound into adsc_top; control and mask fields are shadowed
   from the apb writes seen at the ports.
*/
`timescale 1ns/1ns
`include "adsc_params.svh"

module adsc_top_asserts
(
   // clock and reset
   input wire logic                    pclk,
   input wire logic                    presetn,
   // apb
   input wire adsc_pkg::adsc_apb_req_s apb_req,
   input wire adsc_pkg::adsc_apb_rsp_s apb_rsp,
   // core and analog side
   input wire logic                    core_sleep,
   input wire logic                    core_wake,
   input wire logic [9:0]              conv_sample,
   input wire logic                    analog_powered,
   input wire logic [4:0]              pin_analog,
   input wire logic                    irq
);
   import adsc_pkg::*;
   logic       wr_en;
   logic       on_reg;
   logic       ie_reg;
   logic [1:0] cs_reg;
   logic [2:0] mask_reg;
   // a write takes effect only at the access edge
   assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
   // shadow fields, so power and wake can be judged without the body
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         {on_reg, ie_reg, cs_reg, mask_reg} <= '0;
      else if (wr_en && apb_req.paddr == `ADSC_OFS_CTRL)
      begin
         {ie_reg, cs_reg} <= apb_req.pwdata[8:6];
         on_reg           <= apb_req.pwdata[0];
      end
      else if (wr_en && apb_req.paddr == `ADSC_OFS_IRQ_MASK)
         mask_reg <= apb_req.pwdata[2:0];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_power;
      analog_powered == (on_reg && !(core_sleep && cs_reg != `ADSC_CS_RC));
   endproperty
   a_power: assert property (p_power)
      else $error("converter power level wrong");
   property p_pin_rst;
      $rose(presetn) |-> pin_analog == 5'h1F && !irq && !core_wake;
   endproperty
   a_pin_rst: assert property (p_pin_rst)
      else $error("pins or outputs not reset");
   property p_pin_wr;
      wr_en && apb_req.paddr == `ADSC_OFS_CTRL |=> pin_analog == ~$past(apb_req.pwdata[20:16]);
   endproperty
   a_pin_wr: assert property (p_pin_wr)
      else $error("pin mode not following select");
   property p_wake_cause;
      core_wake |-> ie_reg && $past(core_sleep);
   endproperty
   a_wake_cause: assert property (p_wake_cause)
      else $error("wake without sleep or enable");
   property p_wake_pulse;
      core_wake |=> !core_wake;
   endproperty
   a_wake_pulse: assert property (p_wake_pulse)
      else $error("wake longer than one cycle");
   property p_rc_delay;
      wr_en && apb_req.paddr == `ADSC_OFS_CTRL && apb_req.pwdata[2] && apb_req.pwdata[7:6] == 2'h3
         |=> !core_wake [*8];
   endproperty
   a_rc_delay: assert property (p_rc_delay)
      else $error("rc conversion ended too early");
   property p_irq_mask;
      mask_reg == 3'h0 && $past(mask_reg) == 3'h0 |-> !irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("interrupt while fully masked");
   property p_err_phase;
      apb_rsp.pslverr |-> apb_req.psel && apb_req.penable;
   endproperty
   a_err_phase: assert property (p_err_phase)
      else $error("error outside access phase");
   property p_unmapped;
      apb_req.psel && apb_req.penable && apb_req.paddr > 8'h10 |-> apb_rsp.pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");
endmodule : adsc_top_asserts

bind adsc_top adsc_top_asserts u_chk
(
   .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .core_sleep(core_sleep), .core_wake(core_wake), .conv_sample(conv_sample),
   .analog_powered(analog_powered), .pin_analog(pin_analog), .irq(irq)
);

// >>> verification/adsc_core_model.sv
/*
   core sleep and wake model facing the converter block.
   assumes: bench pulses go_sleep and wake_ext; lazy slows the restart.
*/
`timescale 1ns/1ns

module adsc_core_model
(
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // bench commands
   input  wire logic go_sleep,
   input  wire logic wake_ext,
   input  wire logic lazy,
   // block side
   input  wire logic core_wake,
   output logic      core_sleep
);
   logic [1:0] dly_reg;
   logic       pend_reg;
   // a wake pulse is latched, since the core may take a few cycles to restart
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         core_sleep <= 1'b0;
         pend_reg   <= 1'b0;
         dly_reg    <= 2'h0;
      end
      else if (go_sleep)
         core_sleep <= 1'b1;
      else if (core_sleep && !pend_reg && (core_wake || wake_ext))
      begin
         pend_reg <= 1'b1;
         dly_reg  <= lazy ? 2'h3 : 2'h0;
      end
      else if (pend_reg && dly_reg != 2'h0)
         dly_reg <= dly_reg - 2'h1;
      else if (pend_reg)
      begin
         core_sleep <= 1'b0;
         pend_reg   <= 1'b0;
      end
   end
endmodule : adsc_core_model

// >>> verification/adc_sleep_conversion_control_tb.sv
/*
   bench of the converter sleep control: apb tasks and sleep scenarios.
   assumes: adsc_top, the core model and the bound checker are compiled.
*/
`timescale 1ns/1ns

module adc_sleep_conversion_control_tb;
   import adsc_pkg::*;
   logic          pclk, presetn, go_sleep, wake_ext, lazy, err;
   logic          core_sleep, core_wake, analog_powered, irq;
   logic [9:0]    conv_sample;
   logic [4:0]    pin_analog;
   logic [31:0]   rd;
   adsc_apb_req_s apb_req;
   adsc_apb_rsp_s apb_rsp;
   int            bad_count, n_tests, k;
   adsc_top uut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .core_sleep(core_sleep), .core_wake(core_wake), .conv_sample(conv_sample),
      .analog_powered(analog_powered), .pin_analog(pin_analog), .irq(irq));
   adsc_core_model u_core (.pclk(pclk), .presetn(presetn), .go_sleep(go_sleep),
      .wake_ext(wake_ext), .lazy(lazy), .core_wake(core_wake), .core_sleep(core_sleep));
   // 250 mhz clock
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer; request held until pready is seen high
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      @(posedge pclk);
      apb_req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:addr, pwdata:wd};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      // no wait-state count is assumed; only the watchdog ends a hung wait
      do
      begin
         @(posedge pclk);
      end
      while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask : xfer
   task automatic rdc(input logic [7:0] addr, input logic [31:0] exp);
      xfer(1'b0, addr, 32'h0000_0000);
      chk(rd, exp);
   endtask : rdc
   // s = 1 puts the core to sleep, s = 0 wakes it from outside
   task automatic core_cmd(input logic s);
      @(posedge pclk);
      go_sleep <= s;
      wake_ext <= !s;
      @(posedge pclk);
      go_sleep <= 1'b0;
      wake_ext <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask : core_cmd
   task final_report;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report
   // watchdog, far beyond the several hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      final_report;
   end
   initial
   begin
      presetn = 1'b0;
      apb_req = '0;
      {go_sleep, wake_ext, lazy} = 3'b000;
      conv_sample = 10'h2A5;
      bad_count = 0;
      n_tests = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // reset state, unmapped place refused
      rdc(8'h00, 32'h0000_0000);
      chk({27'h0, pin_analog, analog_powered}, 32'h0000_003E);
      rdc(8'h10, 32'h0000_0000);
      xfer(1'b1, 8'h14, 32'hFFFF_FFFF);
      chk({31'h0, err}, 32'h0000_0001);
      // awake conversion on the fastest clock
      xfer(1'b1, 8'h00, 32'h000A_0005);
      @(posedge pclk);
      chk({27'h0, pin_analog}, 32'h0000_0015);
      k = 0;
      do
      begin
         xfer(1'b0, 8'h00, 32'h0000_0000);
         k++;
      end
      while (rd[2] && k < 50);
      chk(rd, 32'h000A_0001);
      rdc(8'h08, 32'h0000_02A5);
      rdc(8'h0C, 32'h0000_0001);
      rdc(8'h0C, 32'h0000_0000);
      // rc clock with interrupt: sleep right after go, slow core restart
      conv_sample <= 10'h0F0;
      lazy <= 1'b1;
      xfer(1'b1, 8'h10, 32'h0000_0001);
      xfer(1'b1, 8'h00, 32'h0000_01C5);
      core_cmd(1'b1);
      k = 0;
      while (core_wake !== 1'b1 && k < 400)
      begin
         @(posedge pclk);
         k++;
      end
      chk({30'h0, core_wake, irq}, 32'h0000_0003);
      repeat (8) @(posedge pclk);
      chk({31'h0, core_sleep}, 32'h0000_0000);
      rdc(8'h00, 32'h0000_01C1);
      rdc(8'h08, 32'h0000_00F0);
      rdc(8'h0C, 32'h0000_0005);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0000_0000);
      // rc clock without interrupt: core keeps sleeping
      conv_sample <= 10'h30C;
      lazy <= 1'b0;
      xfer(1'b1, 8'h00, 32'h0000_00C5);
      core_cmd(1'b1);
      repeat (260) @(posedge pclk);
      chk({31'h0, core_sleep}, 32'h0000_0001);
      rdc(8'h00, 32'h0000_00C1);
      rdc(8'h08, 32'h0000_030C);
      rdc(8'h0C, 32'h0000_0001);
      rdc(8'h04, 32'h0000_0006);
      core_cmd(1'b0);
      // other clock: sleep aborts and powers down
      xfer(1'b1, 8'h00, 32'h0000_0045);
      core_cmd(1'b1);
      chk({31'h0, analog_powered}, 32'h0000_0000);
      rdc(8'h00, 32'h0000_0041);
      rdc(8'h0C, 32'h0000_0002);
      rdc(8'h04, 32'h0000_0004);
      rdc(8'h08, 32'h0000_030C);
      core_cmd(1'b0);
      chk({31'h0, analog_powered}, 32'h0000_0001);
      // reset in mid-conversion keeps the old result
      conv_sample <= 10'h155;
      xfer(1'b1, 8'h00, 32'h0001_0005);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdc(8'h00, 32'h0000_0000);
      chk({27'h0, pin_analog}, 32'h0000_001F);
      rdc(8'h08, 32'h0000_030C);
      rdc(8'h0C, 32'h0000_0000);
      final_report;
   end
endmodule : adc_sleep_conversion_control_tb
